// ### multi_mode_video_timing_gen.v
// multi_mode_video_timing_gen.v
// raster timing generator: dot and line counters, active window,
// active-low horizontal, vertical and composite sync for six modes.
// assumes i_clk is the dot clock of the selected mode, supplied by an
// external synthesiser steered from o_dot_khz; i_mode_sel and
// i_builtin_monitor are static straps or slow levels from outside.
`timescale 1ns/1ps
`include "video_timing_map.vh"

// Overview of operation
// - active dots 512, 640, 640 per line
// - active dots 800, 800, 832 per line
// - horizontal front porch 16, 64, 16 dots
// - horizontal front porch 40, 56, 32 dots
// - horizontal sync 32, 64, 96 dots
// - horizontal sync 128, 120, 64 dots
// - horizontal back porch 80, 96, 48 dots
// - horizontal back porch 88, 64, 224 dots
// - active lines 384, 480, 480 per frame
// - active lines 600, 600, 624 per frame
// - vertical front porch 1, 3, 10 lines
// - vertical front porch 1, 37, 1 lines
// - vertical sync 3, 3, 2 lines
// - vertical sync 4, 6, 3 lines
// - vertical back porch 19, 39, 33 lines
// - vertical back porch 23, 23, 39 lines
// - dot clock 15.67, 30.24, 25.18 MHz
// - dot clock 40, 50, 57.2832 MHz
// - built-in monitor refuses the 512x384 mode
// - reset starts in 640x480 mode
// - sync outputs are active low
module multi_mode_video_timing_gen (
    // clock and reset
    input  wire                  i_clk,
    input  wire                  i_reset,
    // mode control
    input  wire [`MODE_W-1:0]    i_mode_sel,
    input  wire                  i_builtin_monitor,
    // sync to the monitor
    output reg                   o_hsync_out_n,
    output reg                   o_vsync_out_n,
    output reg                   o_composite_sync_out_n,
    // active window and position
    output reg                   o_active_video,
    output reg  [`CNT_W-1:0]     o_dot_x,
    output reg  [`CNT_W-1:0]     o_line_y,
    output reg                   o_frame_start,
    // mode status
    output reg  [`MODE_W-1:0]    o_mode,
    output reg  [`DOT_KHZ_W-1:0] o_dot_khz
);

    // ------------------------------------------------------------------
    // phase codes within a line or a frame
    // ------------------------------------------------------------------
    localparam [1:0] PH_ACT = 2'h0;  // active video
    localparam [1:0] PH_FP  = 2'h1;  // front porch
    localparam [1:0] PH_SY  = 2'h2;  // sync pulse
    localparam [1:0] PH_BP  = 2'h3;  // back porch

    localparam [`CNT_W-1:0] CNT_ONE = 11'h001;  // counter step

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    reg  [`MODE_W-1:0]    msel_meta_reg;   // first stage, mode select
    reg  [`MODE_W-1:0]    msel_sync_reg;   // second stage, mode select
    reg  [`MODE_W-1:0]    msel_hold_reg;   // copy of second stage, one dot older
    reg                   bltin_meta_reg;  // first stage, built-in strap
    reg                   bltin_sync_reg;  // second stage, built-in strap

    // ------------------------------------------------------------------
    // timing state
    // ------------------------------------------------------------------
    reg  [`MODE_W-1:0]    mode_reg;        // mode in force this frame
    reg  [`MODE_W-1:0]    mode_next;
    reg  [1:0]            hph_reg;         // horizontal phase
    reg  [1:0]            hph_next;
    reg  [`CNT_W-1:0]     hcnt_reg;        // dots left-side count in phase
    reg  [`CNT_W-1:0]     hcnt_next;
    reg  [1:0]            vph_reg;         // vertical phase
    reg  [1:0]            vph_next;
    reg  [`CNT_W-1:0]     vcnt_reg;        // lines in phase so far
    reg  [`CNT_W-1:0]     vcnt_next;
    reg  [`CNT_W-1:0]     x_reg;           // dot within active line
    reg  [`CNT_W-1:0]     x_next;
    reg  [`CNT_W-1:0]     y_reg;           // line within active frame
    reg  [`CNT_W-1:0]     y_next;

    // ------------------------------------------------------------------
    // timing set of the mode in force
    // ------------------------------------------------------------------
    wire [`CNT_W-1:0]     h_act;
    wire [`CNT_W-1:0]     h_fp;
    wire [`CNT_W-1:0]     h_sy;
    wire [`CNT_W-1:0]     h_bp;
    wire [`CNT_W-1:0]     v_act;
    wire [`CNT_W-1:0]     v_fp;
    wire [`CNT_W-1:0]     v_sy;
    wire [`CNT_W-1:0]     v_bp;
    wire [`DOT_KHZ_W-1:0] dot_khz;

    reg  [`CNT_W-1:0]     h_len;           // length of current h phase
    reg  [`CNT_W-1:0]     v_len;           // length of current v phase
    reg                   line_end;        // last dot of the line
    reg                   frame_end;       // last dot of the frame
    reg  [`MODE_W-1:0]    mode_req;        // filtered mode request

    video_mode_table u_table (
        .i_mode    (mode_reg),
        .o_h_act   (h_act),
        .o_h_fp    (h_fp),
        .o_h_sy    (h_sy),
        .o_h_bp    (h_bp),
        .o_v_act   (v_act),
        .o_v_fp    (v_fp),
        .o_v_sy    (v_sy),
        .o_v_bp    (v_bp),
        .o_dot_khz (dot_khz)
    );

    // ------------------------------------------------------------------
    // synchronisers: mode select and strap are asynchronous levels
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_reset) begin
            msel_meta_reg  <= `MODE_RESET;
            msel_sync_reg  <= `MODE_RESET;
            msel_hold_reg  <= `MODE_RESET;
            bltin_meta_reg <= 1'b0;
            bltin_sync_reg <= 1'b0;
        end else begin
            msel_meta_reg  <= i_mode_sel;
            msel_sync_reg  <= msel_meta_reg;
            msel_hold_reg  <= msel_sync_reg;
            bltin_meta_reg <= i_builtin_monitor;
            bltin_sync_reg <= bltin_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // mode request filter
    // ------------------------------------------------------------------
    // the built-in panel has no 512x384 setting; such a request, or an
    // unused code, keeps the mode in force rather than guessing
    always @* begin
        if (msel_sync_reg > `MODE_16IN) begin
            mode_req = mode_reg;
        end else if (msel_sync_reg != msel_hold_reg) begin
            // bits of a changing code may settle apart; wait until steady
            mode_req = mode_reg;
        end else if (bltin_sync_reg && (msel_sync_reg == `MODE_12IN)) begin
            mode_req = mode_reg;
        end else begin
            mode_req = msel_sync_reg;
        end
    end

    // ------------------------------------------------------------------
    // phase lengths
    // ------------------------------------------------------------------
    always @* begin
        case (hph_reg)
            PH_ACT:  h_len = h_act;
            PH_FP:   h_len = h_fp;
            PH_SY:   h_len = h_sy;
            PH_BP:   h_len = h_bp;
            default: h_len = h_act;
        endcase
        case (vph_reg)
            PH_ACT:  v_len = v_act;
            PH_FP:   v_len = v_fp;
            PH_SY:   v_len = v_sy;
            PH_BP:   v_len = v_bp;
            default: v_len = v_act;
        endcase
        line_end  = (hph_reg == PH_BP) && (hcnt_reg == h_len - CNT_ONE);
        frame_end = line_end && (vph_reg == PH_BP) && (vcnt_reg == v_len - CNT_ONE);
    end

    // ------------------------------------------------------------------
    // next-state: horizontal phase walk, then vertical per line
    // ------------------------------------------------------------------
    always @* begin
        hph_next  = hph_reg;
        hcnt_next = hcnt_reg + CNT_ONE;
        vph_next  = vph_reg;
        vcnt_next = vcnt_reg;
        mode_next = mode_reg;
        x_next    = (hph_reg == PH_ACT) ? x_reg + CNT_ONE : x_reg;
        y_next    = y_reg;
        // end of a horizontal phase moves to the next in fixed order
        if (hcnt_reg == h_len - CNT_ONE) begin
            hcnt_next = {`CNT_W{1'b0}};
            case (hph_reg)
                PH_ACT:  hph_next = PH_FP;
                PH_FP:   hph_next = PH_SY;
                PH_SY:   hph_next = PH_BP;
                PH_BP:   hph_next = PH_ACT;
                default: hph_next = PH_ACT;
            endcase
        end
        // each finished line advances the vertical walk
        if (line_end) begin
            x_next    = {`CNT_W{1'b0}};
            vcnt_next = vcnt_reg + CNT_ONE;
            if (vph_reg == PH_ACT) begin
                y_next = y_reg + CNT_ONE;
            end
            if (vcnt_reg == v_len - CNT_ONE) begin
                vcnt_next = {`CNT_W{1'b0}};
                case (vph_reg)
                    PH_ACT:  vph_next = PH_FP;
                    PH_FP:   vph_next = PH_SY;
                    PH_SY:   vph_next = PH_BP;
                    PH_BP:   vph_next = PH_ACT;
                    default: vph_next = PH_ACT;
                endcase
            end
        end
        // mode swap only between frames, so no torn frame reaches the
        // monitor; the counters restart cleanly in the new set
        if (frame_end) begin
            y_next    = {`CNT_W{1'b0}};
            mode_next = mode_req;
        end
    end

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_reset) begin
            mode_reg <= `MODE_RESET;
            hph_reg  <= PH_ACT;
            hcnt_reg <= {`CNT_W{1'b0}};
            vph_reg  <= PH_ACT;
            vcnt_reg <= {`CNT_W{1'b0}};
            x_reg    <= {`CNT_W{1'b0}};
            y_reg    <= {`CNT_W{1'b0}};
        end else begin
            mode_reg <= mode_next;
            hph_reg  <= hph_next;
            hcnt_reg <= hcnt_next;
            vph_reg  <= vph_next;
            vcnt_reg <= vcnt_next;
            x_reg    <= x_next;
            y_reg    <= y_next;
        end
    end

    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------
    // outputs lag the phase state by one dot; all of them lag alike so
    // the sync edges keep their place relative to active video
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_hsync_out_n          <= 1'b1;
            o_vsync_out_n          <= 1'b1;
            o_composite_sync_out_n <= 1'b1;
            o_active_video         <= 1'b0;
            o_dot_x                <= {`CNT_W{1'b0}};
            o_line_y               <= {`CNT_W{1'b0}};
            o_frame_start          <= 1'b0;
            o_mode                 <= `MODE_RESET;
            o_dot_khz              <= `DOT_KHZ_VGA;
        end else begin
            // low while in the sync phase
            o_hsync_out_n <= ~(hph_reg == PH_SY);
            o_vsync_out_n <= ~(vph_reg == PH_SY);
            // composite is the and of both pulses, low when either is
            o_composite_sync_out_n <= ~((hph_reg == PH_SY) | (vph_reg == PH_SY));
            // blanking held outside active video
            o_active_video <= (hph_reg == PH_ACT) && (vph_reg == PH_ACT);
            o_dot_x        <= x_reg;
            o_line_y       <= y_reg;
            o_frame_start  <= (hph_reg == PH_ACT) && (hcnt_reg == {`CNT_W{1'b0}})
                              && (vph_reg == PH_ACT) && (vcnt_reg == {`CNT_W{1'b0}});
            o_mode         <= mode_reg;
            o_dot_khz      <= dot_khz;
        end
    end

endmodule // multi_mode_video_timing_gen

// ### video_timing_map.vh
// video_timing_map.vh
// constants for the multi mode raster timing generator: mode codes,
// per-mode horizontal and vertical lengths, dot clock rates in khz.
// assumes inclusion by bare name from the generator and its table.
`ifndef VIDEO_TIMING_MAP_VH
`define VIDEO_TIMING_MAP_VH

// ----------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------
`define MODE_W            3
`define MODE_12IN         3'h0
`define MODE_14IN         3'h1
`define MODE_VGA          3'h2
`define MODE_SVGA60       3'h3
`define MODE_SVGA72       3'h4
`define MODE_16IN         3'h5
`define MODE_RESET        3'h2

// ----------------------------------------------------------------------
// counter width
// ----------------------------------------------------------------------
`define CNT_W             11

// ----------------------------------------------------------------------
// horizontal lengths in dots
// ----------------------------------------------------------------------
`define H_ACT_12IN        11'h200
`define H_ACT_14IN        11'h280
`define H_ACT_VGA         11'h280
`define H_ACT_SVGA60      11'h320
`define H_ACT_SVGA72      11'h320
`define H_ACT_16IN        11'h340
`define H_FP_12IN         11'h010
`define H_FP_14IN         11'h040
`define H_FP_VGA          11'h010
`define H_FP_SVGA60       11'h028
`define H_FP_SVGA72       11'h038
`define H_FP_16IN         11'h020
`define H_SY_12IN         11'h020
`define H_SY_14IN         11'h040
`define H_SY_VGA          11'h060
`define H_SY_SVGA60       11'h080
`define H_SY_SVGA72       11'h078
`define H_SY_16IN         11'h040
`define H_BP_12IN         11'h050
`define H_BP_14IN         11'h060
`define H_BP_VGA          11'h030
`define H_BP_SVGA60       11'h058
`define H_BP_SVGA72       11'h040
`define H_BP_16IN         11'h0E0

// ----------------------------------------------------------------------
// vertical lengths in lines
// ----------------------------------------------------------------------
`define V_ACT_12IN        11'h180
`define V_ACT_14IN        11'h1E0
`define V_ACT_VGA         11'h1E0
`define V_ACT_SVGA60      11'h258
`define V_ACT_SVGA72      11'h258
`define V_ACT_16IN        11'h270
`define V_FP_12IN         11'h001
`define V_FP_14IN         11'h003
`define V_FP_VGA          11'h00A
`define V_FP_SVGA60       11'h001
`define V_FP_SVGA72       11'h025
`define V_FP_16IN         11'h001
`define V_SY_12IN         11'h003
`define V_SY_14IN         11'h003
`define V_SY_VGA          11'h002
`define V_SY_SVGA60       11'h004
`define V_SY_SVGA72       11'h006
`define V_SY_16IN         11'h003
`define V_BP_12IN         11'h013
`define V_BP_14IN         11'h027
`define V_BP_VGA          11'h021
`define V_BP_SVGA60       11'h017
`define V_BP_SVGA72       11'h017
`define V_BP_16IN         11'h027

// ----------------------------------------------------------------------
// dot clock rate expected on i_clk per mode, in khz (informative)
// ----------------------------------------------------------------------
`define DOT_KHZ_W         17
`define DOT_KHZ_12IN      17'h03D36
`define DOT_KHZ_14IN      17'h07620
`define DOT_KHZ_VGA       17'h0625C
`define DOT_KHZ_SVGA60    17'h09C40
`define DOT_KHZ_SVGA72    17'h0C350
`define DOT_KHZ_16IN      17'h0DFC3

`endif

// ### video_mode_table.v
// video_mode_table.v
// combinational lookup of one mode's timing set and dot clock rate.
// assumes a registered mode code from the generator on the same clock.
`timescale 1ns/1ps
`include "video_timing_map.vh"

module video_mode_table (
    // mode select
    input  wire [`MODE_W-1:0]    i_mode,
    // horizontal set
    output reg  [`CNT_W-1:0]     o_h_act,
    output reg  [`CNT_W-1:0]     o_h_fp,
    output reg  [`CNT_W-1:0]     o_h_sy,
    output reg  [`CNT_W-1:0]     o_h_bp,
    // vertical set
    output reg  [`CNT_W-1:0]     o_v_act,
    output reg  [`CNT_W-1:0]     o_v_fp,
    output reg  [`CNT_W-1:0]     o_v_sy,
    output reg  [`CNT_W-1:0]     o_v_bp,
    // dot clock rate the mode expects
    output reg  [`DOT_KHZ_W-1:0] o_dot_khz
);

    // ------------------------------------------------------------------
    // table lookup
    // ------------------------------------------------------------------
    // unknown codes fall back to the vga set so timing never stalls
    always @* begin
        case (i_mode)
            `MODE_12IN: begin
                o_h_act = `H_ACT_12IN;
                o_h_fp = `H_FP_12IN;
                o_h_sy = `H_SY_12IN;
                o_h_bp = `H_BP_12IN;
                o_v_act = `V_ACT_12IN;
                o_v_fp = `V_FP_12IN;
                o_v_sy = `V_SY_12IN;
                o_v_bp = `V_BP_12IN;
                o_dot_khz = `DOT_KHZ_12IN;
            end
            `MODE_14IN: begin
                o_h_act = `H_ACT_14IN;
                o_h_fp = `H_FP_14IN;
                o_h_sy = `H_SY_14IN;
                o_h_bp = `H_BP_14IN;
                o_v_act = `V_ACT_14IN;
                o_v_fp = `V_FP_14IN;
                o_v_sy = `V_SY_14IN;
                o_v_bp = `V_BP_14IN;
                o_dot_khz = `DOT_KHZ_14IN;
            end
            `MODE_SVGA60: begin
                o_h_act = `H_ACT_SVGA60;
                o_h_fp = `H_FP_SVGA60;
                o_h_sy = `H_SY_SVGA60;
                o_h_bp = `H_BP_SVGA60;
                o_v_act = `V_ACT_SVGA60;
                o_v_fp = `V_FP_SVGA60;
                o_v_sy = `V_SY_SVGA60;
                o_v_bp = `V_BP_SVGA60;
                o_dot_khz = `DOT_KHZ_SVGA60;
            end
            `MODE_SVGA72: begin
                o_h_act = `H_ACT_SVGA72;
                o_h_fp = `H_FP_SVGA72;
                o_h_sy = `H_SY_SVGA72;
                o_h_bp = `H_BP_SVGA72;
                o_v_act = `V_ACT_SVGA72;
                o_v_fp = `V_FP_SVGA72;
                o_v_sy = `V_SY_SVGA72;
                o_v_bp = `V_BP_SVGA72;
                o_dot_khz = `DOT_KHZ_SVGA72;
            end
            `MODE_16IN: begin
                o_h_act = `H_ACT_16IN;
                o_h_fp = `H_FP_16IN;
                o_h_sy = `H_SY_16IN;
                o_h_bp = `H_BP_16IN;
                o_v_act = `V_ACT_16IN;
                o_v_fp = `V_FP_16IN;
                o_v_sy = `V_SY_16IN;
                o_v_bp = `V_BP_16IN;
                o_dot_khz = `DOT_KHZ_16IN;
            end
            default: begin
                o_h_act = `H_ACT_VGA;
                o_h_fp = `H_FP_VGA;
                o_h_sy = `H_SY_VGA;
                o_h_bp = `H_BP_VGA;
                o_v_act = `V_ACT_VGA;
                o_v_fp = `V_FP_VGA;
                o_v_sy = `V_SY_VGA;
                o_v_bp = `V_BP_VGA;
                o_dot_khz = `DOT_KHZ_VGA;
            end
        endcase
    end

endmodule // video_mode_table

// ### video_monitor_model.sv
// monitor model: measures phase lengths of the last complete line
// assumes sync and active sampled on the dot clock rising edge
`timescale 1ns/1ps
module video_monitor_model (
    // dot clock and signals seen at the monitor
    input  wire logic        i_clk,
    input  wire logic        i_hsync_n,
    input  wire logic        i_active,
    // last measured lengths in dots
    output logic      [11:0] o_act_len,
    output logic      [11:0] o_fp_len,
    output logic      [11:0] o_hs_len,
    output logic      [11:0] o_bp_len
);
    logic [11:0] run  = 12'h000; // dots since last edge of any kind
    logic        hs_q = 1'b1;    // previous sync level
    logic        de_q = 1'b0;    // previous active level
    // each edge closes one phase; blank lines never close back porch
    always @(posedge i_clk) begin
        hs_q <= i_hsync_n;
        de_q <= i_active;
        run  <= (de_q != i_active || hs_q != i_hsync_n) ? 12'h001 : run + 12'h001;
        if (de_q && !i_active) o_act_len <= run;
        if (hs_q && !i_hsync_n) o_fp_len <= run;
        if (!hs_q && i_hsync_n) o_hs_len <= run;
        if (!de_q && i_active) o_bp_len <= run;
    end
endmodule // video_monitor_model

// ### multi_mode_video_timing_gen_props.sv
// checker: per-mode line and sync lengths of the timing generator
// assumes binding to the generator top; one clock domain
`timescale 1ns/1ps
module multi_mode_video_timing_gen_props (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_reset,
    // generator outputs
    input wire logic        o_hsync_out_n,
    input wire logic        o_vsync_out_n,
    input wire logic        o_composite_sync_out_n,
    input wire logic        o_active_video,
    input wire logic [10:0] o_dot_x,
    input wire logic [10:0] o_line_y,
    input wire logic        o_frame_start,
    input wire logic [2:0]  o_mode,
    input wire logic [16:0] o_dot_khz
);
    // lengths indexed by mode code
    localparam int HACT[6] = '{512, 640, 640, 800, 800, 832};
    localparam int HFP[6]  = '{16, 64, 16, 40, 56, 32};
    localparam int HSY[6]  = '{32, 64, 96, 128, 120, 64};
    localparam int HBP[6]  = '{80, 96, 48, 88, 64, 224};
    localparam int VSY[6]  = '{3, 3, 2, 4, 6, 3};
    localparam int KHZ[6]  = '{15670, 30240, 25180, 40000, 50000, 57283};
    logic [11:0] n_act, n_fp, n_hs, n_bp; // run lengths of each phase
    logic [3:0]  n_vs;                    // hsync falls under vertical sync
    // back porch starts high so the line cut by reset is not judged
    always @(posedge i_clk) begin
        if (i_reset) begin
            n_act <= 12'h000;
            n_fp  <= 12'h000;
            n_hs  <= 12'h000;
            n_bp  <= 12'h800;
            n_vs  <= 4'h0;
        end else begin
            n_act <= o_active_video ? n_act + 12'h001 : 12'h000;
            n_fp  <= o_active_video ? 12'h000 : n_fp + {11'h000, n_fp != 12'hFFF};
            n_hs  <= o_hsync_out_n ? 12'h000 : n_hs + 12'h001;
            n_bp  <= o_hsync_out_n ? n_bp + 12'h001 : 12'h000;
            n_vs  <= o_vsync_out_n ? 4'h0 : n_vs + {3'h0, $fell(o_hsync_out_n)};
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_composite_sync_out_n_and: assert property (
        o_composite_sync_out_n == (o_hsync_out_n & o_vsync_out_n)) else $error("composite_sync_out_n bad");
    a_reset_state: assert property (
        $fell(i_reset) |-> o_mode == 3'h2 && o_dot_khz == 17'h0625C && o_hsync_out_n
        && o_vsync_out_n && !o_active_video ##[1:2] o_frame_start) else $error("reset bad");
    a_active_len: assert property (
        $fell(o_active_video) |-> n_act == HACT[o_mode]) else $error("active length bad");
    a_fp_len: assert property (
        $fell(o_hsync_out_n) && n_fp < 12'h100 |-> n_fp == HFP[o_mode]) else $error("fp bad");
    a_hsync_len: assert property (
        $rose(o_hsync_out_n) |-> n_hs == HSY[o_mode]) else $error("hsync length bad");
    a_bp_len: assert property (
        $rose(o_active_video) && n_bp < 12'h100 |-> n_bp == HBP[o_mode]) else $error("bp bad");
    a_vsync_len: assert property (
        $rose(o_vsync_out_n) |-> n_vs == VSY[o_mode]) else $error("vsync length bad");
    a_dot_step: assert property (
        o_active_video && $past(o_active_video) |-> o_dot_x == $past(o_dot_x) + 11'h001)
        else $error("dot index bad");
    a_frame_origin: assert property (
        o_frame_start |-> o_active_video && o_dot_x == 11'h000 && o_line_y == 11'h000)
        else $error("frame origin bad");
    a_mode_frame: assert property (
        $changed(o_mode) |-> ##[0:1] o_frame_start) else $error("mode change mid frame");
    a_rate_match: assert property (
        o_mode < 3'h6 && o_dot_khz == KHZ[o_mode]) else $error("rate bad");
endmodule // multi_mode_video_timing_gen_props

bind multi_mode_video_timing_gen multi_mode_video_timing_gen_props u_props (
    .i_clk(i_clk), .i_reset(i_reset), .o_hsync_out_n(o_hsync_out_n),
    .o_vsync_out_n(o_vsync_out_n), .o_composite_sync_out_n(o_composite_sync_out_n),
    .o_active_video(o_active_video), .o_dot_x(o_dot_x), .o_line_y(o_line_y),
    .o_frame_start(o_frame_start), .o_mode(o_mode), .o_dot_khz(o_dot_khz));

// ### multi_mode_video_timing_gen_test.sv
// testbench: reset state, one full default-mode line, mode hold
// assumes a 100 MHz clock; a whole frame is too long, so lines only
`timescale 1ns/1ps
module multi_mode_video_timing_gen_test;
    logic        i_clk = 1'b0;          // dot clock
    logic        i_reset = 1'b1;        // held from time zero
    logic [2:0]  i_mode_sel = 3'h2;     // requested mode
    logic        i_builtin_monitor = 1'b0;
    logic        hs_n, vs_n, cs_n, act, fs;
    logic [10:0] dot_x, line_y;
    logic [2:0]  mode;
    logic [16:0] khz;
    logic [11:0] m_act, m_fp, m_hs, m_bp; // monitor measurements
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cycles = 0;
    always #5 i_clk = ~i_clk;
    multi_mode_video_timing_gen u_multi_mode_video_timing_gen (
        .i_clk(i_clk), .i_reset(i_reset), .i_mode_sel(i_mode_sel),
        .i_builtin_monitor(i_builtin_monitor), .o_hsync_out_n(hs_n), .o_vsync_out_n(vs_n),
        .o_composite_sync_out_n(cs_n), .o_active_video(act), .o_dot_x(dot_x),
        .o_line_y(line_y), .o_frame_start(fs), .o_mode(mode), .o_dot_khz(khz));
    video_monitor_model u_video_monitor_model (
        .i_clk(i_clk), .i_hsync_n(hs_n), .i_active(act), .o_act_len(m_act),
        .o_fp_len(m_fp), .o_hs_len(m_hs), .o_bp_len(m_bp));
    // hang guard: the run needs about 5000 cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic summarize;
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [16:0] exp, input logic [16:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s: expected %0h, seen %0h", nm, exp, got);
        end
    endtask
    // two reset edges, outputs checked while still in reset
    task automatic t_restart;
        int a = 0, f = 0, h = 0, b = 0, bad = 0;
        @(posedge i_clk);
        i_reset <= 1'b1;
        @(posedge i_clk);
        @(negedge i_clk);
        check("syncs active start fs mode", 8'hE2, {hs_n, vs_n, cs_n, act, fs, mode});
        check("dot rate", 17'h0625C, khz);
        @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) begin
            @(negedge i_clk);
            if (fs === 1'b1) break;
        end
        check("frame start at x0", 12'h800, {fs, dot_x});
        // classify each of the 800 dots of the first line
        for (int i = 0; i < 800; i++) begin
            if (act === 1'b1) a++;
            else if (hs_n === 1'b0) h++;
            else if (h == 0) f++;
            else b++;
            if (cs_n !== hs_n) bad++;
            @(negedge i_clk);
        end
        check("active dots", 640, a);
        check("front porch", 16, f);
        check("hsync dots", 96, h);
        check("back porch", 48, b);
        check("composite_sync_out_n follows hsync", 0, bad);
        check("next line start", 12'h801, {act, line_y});
    endtask
    // monitor view of a later line
    task automatic t_monitor;
        repeat (1600) @(negedge i_clk);
        check("monitor act", 640, m_act);
        check("monitor fp", 16, m_fp);
        check("monitor hsync", 96, m_hs);
        check("monitor bp", 48, m_bp);
    endtask
    // refused and unused mode codes must not change the mode in force
    task automatic t_mode_hold;
        @(posedge i_clk);
        i_builtin_monitor <= 1'b1;
        i_mode_sel <= 3'h0;
        repeat (900) @(negedge i_clk);
        check("mode with refused code", 3'h2, mode);
        @(posedge i_clk);
        i_builtin_monitor <= 1'b0;
        i_mode_sel <= 3'h7;
        repeat (900) @(negedge i_clk);
        check("mode with bad code", 3'h2, mode);
        @(posedge i_clk);
        i_mode_sel <= 3'h3;
    endtask
    initial begin
        t_restart();
        t_monitor();
        t_mode_hold();
        t_restart();
        summarize();
    end
endmodule // multi_mode_video_timing_gen_test
